/* File: logic/ulpi_ctrl_pkg.sv */
// Offsets, field positions, reset values and timing of the control bank
package ulpi_ctrl_pkg;

  typedef logic [5:0] addr_t;  // Register address
  typedef logic [7:0] byte_t;  // Register data

  // Access kinds decoded from the address
  typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_SET, OP_CLEAR} op_t;

  // Transceiver function register
  localparam addr_t FUNC_WR  = 6'h04;
  localparam addr_t FUNC_SET = 6'h05;
  localparam addr_t FUNC_CLR = 6'h06;
  // Interface mode register
  localparam addr_t IFC_WR   = 6'h07;
  localparam addr_t IFC_SET  = 6'h08;
  localparam addr_t IFC_CLR  = 6'h09;
  // On-the-go line register
  localparam addr_t OTG_WR   = 6'h0a;
  localparam addr_t OTG_SET  = 6'h0b;
  localparam addr_t OTG_CLR  = 6'h0c;

  // Reset values and the function register's writable mask
  localparam byte_t FUNC_RST  = 8'h41;
  localparam byte_t FUNC_MASK = 8'h7f;
  localparam byte_t IFC_RST   = 8'h00;
  localparam byte_t OTG_RST   = 8'h06;

  // Transceiver function fields
  localparam int SPD_LO  = 0;
  localparam int TERM    = 2;
  localparam int ENC_LO  = 3;
  localparam int XRST    = 5;
  localparam int SUSP    = 6;
  // Interface mode fields
  localparam int SER6    = 0;
  localparam int SER3    = 1;
  localparam int CARKIT  = 2;
  localparam int CLKON   = 3;
  localparam int ARES    = 4;
  localparam int VINV    = 5;
  localparam int VBYP    = 6;
  localparam int STPDIS  = 7;
  // On-the-go line fields
  localparam int IDPU    = 0;
  localparam int DPPD    = 1;
  localparam int DMPD    = 2;
  localparam int DISCH   = 3;
  localparam int CHRG    = 4;
  localparam int DRV     = 5;
  localparam int DRVALT  = 6;
  localparam int EXTSEL  = 7;

  // Speed and encoding codes
  localparam logic [1:0] SPD_HS   = 2'h0;
  localparam logic [1:0] SPD_FS   = 2'h1;
  localparam logic [1:0] SPD_LS   = 2'h2;
  localparam logic [1:0] SPD_PRE  = 2'h3;
  localparam logic [1:0] ENC_NORM = 2'h0;
  localparam logic [1:0] ENC_NDRV = 2'h1;
  localparam logic [1:0] ENC_RAW  = 2'h2;

  // Transceiver reset hold time
  localparam int CLK_MHZ     = 10;
  localparam int XRST_NS     = 1000;
  localparam int XRST_CYCLES = (XRST_NS * CLK_MHZ + 999) / 1000;

endpackage

/* File: logic/xcvr_rst_if.sv */
// Request and completion of a transceiver reset
`timescale 1ns/10ps
`default_nettype none
interface xcvr_rst_if;
  logic start;  // One-cycle request
  logic busy;   // Reset in progress
  logic done;   // One-cycle completion
  modport ctrl (output start, input busy, input done);
  modport seq  (input start, output busy, output done);
endinterface
`default_nettype wire

/* File: logic/xcvr_reset_seq.sv */
// Timed transceiver reset pulse generator
`timescale 1ns/10ps
`default_nettype none
module xcvr_reset_seq #(
  parameter int CYCLES = ulpi_ctrl_pkg::XRST_CYCLES
) (
  input  wire logic   sys_clk,
  input  wire logic   rst_b,
  xcvr_rst_if.seq     link,
  output logic        xcvr_reset_out
);
  import ulpi_ctrl_pkg::*;

  localparam int MAX_WAIT = CYCLES + 1;  // Start to done, in cycles

  // Refuse lengths the counter cannot hold
  if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
    $error("xcvr_reset_seq: CYCLES out of range");
  end

  typedef enum logic {ST_IDLE, ST_HOLD} seq_state_t;

  seq_state_t state_q;    // Sequencer state
  logic [7:0] count_q;    // Cycles left in hold
  logic       done_q;     // Completion pulse

  // RQ8 - hold reset, then finish
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      count_q <= 8'h00;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Start a fresh hold
          if (link.start) begin
            state_q <= ST_HOLD;
            count_q <= 8'(CYCLES - 1);
          end
        end
        ST_HOLD: begin
          // Count down, then report
          if (count_q == 8'h00) begin
            state_q <= ST_IDLE;
            done_q  <= 1'b1;
          end else begin
            count_q <= count_q - 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign link.busy      = (state_q == ST_HOLD);
  assign link.done      = done_q;
  assign xcvr_reset_out = (state_q == ST_HOLD);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_reset_ends: assert property ( // RQ8
    (link.start && state_q == ST_IDLE) |-> ##[1:MAX_WAIT] done_q)
    else $error("transceiver reset never finished");
  a_done_after_hold: assert property ( // RQ8
    done_q |-> $past(xcvr_reset_out) && !xcvr_reset_out)
    else $error("done without a preceding hold");
  c_reset_run: cover property (link.start ##[1:MAX_WAIT] done_q);
endmodule
`default_nettype wire

/* File: logic/ulpi_phy_control_registers.sv */
// Transceiver, interface mode and on-the-go control registers
//
// Operation
// RQ1 - Function register: read three, write/set/clear.
// RQ2 - Interface register: write/set/clear, read any.
// RQ3 - On-the-go register: write/set/clear, read any.
// RQ4 - Speed 00 HS, 01 FS, 10 LS.
// RQ5 - Speed 11: FS with automatic preamble.
// RQ6 - Termination bit steers line termination.
// RQ7 - Encoding: normal, non-driving, raw; 11 reserved.
// RQ8 - Reset bit resets transceiver, self-clears; not cleared if a function register write lands in the done cycle.
// RQ9 - Suspend low enters low power; self-sets.
// RQ10 - Six-pin serial mode, cleared on exit; not cleared if an interface register write lands in the same cycle.
// RQ11 - Three-pin serial mode, cleared on exit; not cleared if an interface register write lands in the same cycle.
// RQ12 - Car-kit mode, cleared on exit; not cleared if an interface register write lands in the same cycle.
// RQ13 - Keep clock running in serial modes.
// RQ14 - Host-only automatic resume signalling.
// RQ15 - Invert external indicator input.
// RQ16 - Bypass ANDing comparator with indicator.
// RQ17 - Disconnect stop-line guard pull-up.
// RQ18 - Identification pin pull-up enable.
// RQ19 - Data-line pull-downs, both reset on.
// RQ20 - VBUS discharge and charge resistors.
// RQ21 - Charge pump on if either drive bit.
// RQ22 - Select external indicator as VBUS-valid.
// RQ23 - Reserved function bit reads zero.
`timescale 1ns/10ps
`default_nettype none
module ulpi_phy_control_registers (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // Register access port
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire ulpi_ctrl_pkg::addr_t reg_addr,
  input  wire ulpi_ctrl_pkg::byte_t reg_wdata,
  output ulpi_ctrl_pkg::byte_t      reg_rdata,
  output logic                      reg_rvalid,
  // Events from the rest of the device
  input  wire logic                 low_power_exit,
  input  wire logic                 serial_mode_exit,
  input  wire logic                 car_kit_mode_exit,
  input  wire logic                 host_mode,
  input  wire logic                 vbus_comparator_valid,
  input  wire logic                 external_vbus_input,
  // Transceiver controls
  output logic                      hs_xcvr_enable,
  output logic                      fs_xcvr_enable,
  output logic                      ls_xcvr_enable,
  output logic                      fs_preamble_enable,
  output logic                      termination_select,
  output logic [1:0]                encoding_mode_select,
  output logic                      non_driving,
  output logic                      raw_encoding,
  output logic                      xcvr_reset_out,
  output logic                      low_power_request,
  // Pin mode controls
  output logic                      six_pin_serial_enable,
  output logic                      three_pin_serial_enable,
  output logic                      car_kit_uart_enable,
  output logic                      clock_output_pin_enable,
  output logic                      automatic_resume_active,
  output logic                      stop_guard_pullup_enable,
  // Line and supply controls
  output logic                      id_pin_pullup_enable,
  output logic                      dplus_pulldown_enable,
  output logic                      dminus_pulldown_enable,
  output logic                      vbus_discharge_enable,
  output logic                      vbus_charge_enable,
  output logic                      charge_pump_enable_pin,
  output logic                      vbus_valid
);
  import ulpi_ctrl_pkg::*;

  byte_t func_q, func_d;  // Transceiver function
  byte_t ifc_q, ifc_d;    // Interface mode
  byte_t otg_q, otg_d;    // On-the-go line
  op_t   func_op;         // Access to function
  op_t   ifc_op;          // Access to interface
  op_t   otg_op;          // Access to on-the-go
  logic  ext_meta_q;      // Indicator sync stage 1
  logic  ext_sync_q;      // Indicator sync stage 2

  xcvr_rst_if rif ();     // Link to reset timer

  // Kind of access aimed at one register
  function automatic op_t decode(input addr_t a, input addr_t wr_a,
                                 input addr_t set_a, input addr_t clr_a);
    op_t r;
    r = OP_NONE;
    if (a == wr_a) begin
      r = OP_WRITE;
    end else if (a == set_a) begin
      r = OP_SET;
    end else if (a == clr_a) begin
      r = OP_CLEAR;
    end
    return r;
  endfunction

  // New contents after write, set or clear
  function automatic byte_t apply(input byte_t cur, input byte_t d,
                                  input op_t op);
    byte_t r;
    r = cur;
    case (op)
      OP_WRITE: r = d;
      OP_SET:   r = cur | d;
      OP_CLEAR: r = cur & ~d;
      default:  r = cur;
    endcase
    return r;
  endfunction

  // Address decode, qualified by the write strobe
  always_comb begin
    func_op = OP_NONE;
    ifc_op  = OP_NONE;
    otg_op  = OP_NONE;
    if (reg_wr) begin
      func_op = decode(reg_addr, FUNC_WR, FUNC_SET, FUNC_CLR);
      ifc_op  = decode(reg_addr, IFC_WR, IFC_SET, IFC_CLR);
      otg_op  = decode(reg_addr, OTG_WR, OTG_SET, OTG_CLR);
    end
  end

  // Function next value
  always_comb begin
    // RQ1 - write, set, clear
    // RQ23 - reserved bit masked
    func_d = apply(func_q, reg_wdata, func_op) & FUNC_MASK;
    // RQ8 - self-clear when done
    if (rif.done && func_op == OP_NONE) begin
      func_d[XRST] = 1'b0;
    end
    // RQ9 - wake sets suspend bit
    if (low_power_exit) begin
      func_d[SUSP] = 1'b1;
    end
  end

  // Interface next value
  always_comb begin
    // RQ2 - write, set, clear
    ifc_d = apply(ifc_q, reg_wdata, ifc_op);
    if (ifc_op == OP_NONE) begin
      // RQ10 - six-pin exit
      // RQ11 - three-pin exit
      if (serial_mode_exit) begin
        ifc_d[SER6] = 1'b0;
        ifc_d[SER3] = 1'b0;
      end
      // RQ12 - car-kit exit
      if (car_kit_mode_exit) begin
        ifc_d[CARKIT] = 1'b0;
      end
    end
  end

  // On-the-go next value
  always_comb begin
    // RQ3 - write, set, clear
    otg_d = apply(otg_q, reg_wdata, otg_op);
  end

  // RQ8 - rising reset bit starts timer
  // A hold already running is never restarted
  assign rif.start = func_d[XRST] & ~func_q[XRST] & ~rif.busy;

  // Register state
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      func_q <= FUNC_RST;
      ifc_q  <= IFC_RST;
      otg_q  <= OTG_RST;
    end else begin
      func_q <= func_d;
      ifc_q  <= ifc_d;
      otg_q  <= otg_d;
    end
  end

  // Read port, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        // RQ1 - any of three addresses
        if (reg_addr >= FUNC_WR && reg_addr <= FUNC_CLR) begin
          reg_rdata <= func_q;
        // RQ2 - any of three addresses
        end else if (reg_addr >= IFC_WR && reg_addr <= IFC_CLR) begin
          reg_rdata <= ifc_q;
        // RQ3 - any of three addresses
        end else if (reg_addr >= OTG_WR && reg_addr <= OTG_CLR) begin
          reg_rdata <= otg_q;
        end else begin
          // Unmapped reads as zero
          reg_rdata <= 8'h00;
        end
      end
    end
  end

  // Indicator pin synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= external_vbus_input;
      ext_sync_q <= ext_meta_q;
    end
  end

  // Transceiver control outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hs_xcvr_enable       <= 1'b0;
      fs_xcvr_enable       <= 1'b1;
      ls_xcvr_enable       <= 1'b0;
      fs_preamble_enable   <= 1'b0;
      termination_select   <= 1'b0;
      encoding_mode_select <= ENC_NORM;
      non_driving          <= 1'b0;
      raw_encoding         <= 1'b0;
      low_power_request    <= 1'b0;
    end else begin
      // RQ4 - speed decode
      hs_xcvr_enable <= func_q[SPD_LO+:2] == SPD_HS;
      ls_xcvr_enable <= func_q[SPD_LO+:2] == SPD_LS;
      // RQ5 - FS carries LS with preamble
      fs_xcvr_enable <= func_q[SPD_LO+:2] == SPD_FS ||
                        func_q[SPD_LO+:2] == SPD_PRE;
      fs_preamble_enable <= func_q[SPD_LO+:2] == SPD_PRE;
      // RQ6 - termination control
      termination_select <= func_q[TERM];
      // RQ7 - encoding decode, 11 acts normal
      encoding_mode_select <= func_q[ENC_LO+:2];
      non_driving  <= func_q[ENC_LO+:2] == ENC_NDRV;
      raw_encoding <= func_q[ENC_LO+:2] == ENC_RAW;
      // RQ9 - low power while suspend low
      low_power_request <= ~func_q[SUSP];
    end
  end

  // Pin mode and line outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      six_pin_serial_enable    <= 1'b0;
      three_pin_serial_enable  <= 1'b0;
      car_kit_uart_enable      <= 1'b0;
      clock_output_pin_enable  <= 1'b1;
      automatic_resume_active  <= 1'b0;
      stop_guard_pullup_enable <= 1'b1;
      id_pin_pullup_enable     <= 1'b0;
      dplus_pulldown_enable    <= 1'b1;
      dminus_pulldown_enable   <= 1'b1;
      vbus_discharge_enable    <= 1'b0;
      vbus_charge_enable       <= 1'b0;
      charge_pump_enable_pin   <= 1'b0;
      vbus_valid               <= 1'b0;
    end else begin
      // RQ10 - six-pin serial pins
      six_pin_serial_enable   <= ifc_q[SER6];
      // RQ11 - three-pin serial pins
      three_pin_serial_enable <= ifc_q[SER3];
      // RQ12 - car-kit pins
      car_kit_uart_enable     <= ifc_q[CARKIT];
      // RQ13 - clock stops in alt modes unless kept
      clock_output_pin_enable <= ifc_q[CLKON] |
        ~(ifc_q[SER6] | ifc_q[SER3] | ifc_q[CARKIT]);
      // RQ14 - host mode only
      automatic_resume_active <= ifc_q[ARES] & host_mode;
      // RQ17 - guard pull-up
      stop_guard_pullup_enable <= ~ifc_q[STPDIS];
      // RQ18 - identification pull-up
      id_pin_pullup_enable   <= otg_q[IDPU];
      // RQ19 - data-line pull-downs
      dplus_pulldown_enable  <= otg_q[DPPD];
      dminus_pulldown_enable <= otg_q[DMPD];
      // RQ20 - VBUS resistors
      vbus_discharge_enable  <= otg_q[DISCH];
      vbus_charge_enable     <= otg_q[CHRG];
      // RQ21 - either drive bit
      charge_pump_enable_pin <= otg_q[DRV] | otg_q[DRVALT];
      // RQ22 - source select
      // RQ15 - invert indicator
      // RQ16 - bypass the AND
      if (otg_q[EXTSEL]) begin
        vbus_valid <= ifc_q[VBYP] ? (ext_sync_q ^ ifc_q[VINV]) :
          ((ext_sync_q ^ ifc_q[VINV]) & vbus_comparator_valid);
      end else begin
        vbus_valid <= vbus_comparator_valid;
      end
    end
  end

  // Transceiver reset timer
  xcvr_reset_seq u_seq (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .link           (rif),
    .xcvr_reset_out (xcvr_reset_out)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_func_write_val: assert property ( // RQ1
    (func_op == OP_WRITE && !low_power_exit && !rif.done)
    |=> func_q == ($past(reg_wdata) & FUNC_MASK))
    else $error("function write not stored");
  a_func_clear_bits: assert property ( // RQ1
    (func_op == OP_CLEAR && !low_power_exit)
    |=> (func_q & $past(reg_wdata)) == 8'h00)
    else $error("function clear left bits set");
  a_ifc_set_bits: assert property ( // RQ2
    (ifc_op == OP_SET) |=> (ifc_q & $past(reg_wdata)) == $past(reg_wdata))
    else $error("interface set lost bits");
  a_otg_read_any: assert property ( // RQ3
    (reg_rd && reg_addr >= OTG_WR && reg_addr <= OTG_CLR)
    |=> reg_rvalid && reg_rdata == $past(otg_q))
    else $error("on-the-go read mismatch");
  a_speed_decode: assert property ( // RQ4
    ##1 hs_xcvr_enable == ($past(func_q[SPD_LO+:2]) == SPD_HS))
    else $error("high-speed enable wrong");
  a_preamble_mode: assert property ( // RQ5
    (func_q[SPD_LO+:2] == SPD_PRE) |=> fs_xcvr_enable && fs_preamble_enable)
    else $error("preamble mode wrong");
  a_reset_clears: assert property ( // RQ8
    (rif.done && func_op == OP_NONE) |=> !func_q[XRST])
    else $error("reset bit not cleared");
  a_wake_sets: assert property ( // RQ9
    low_power_exit |=> func_q[SUSP] ##1 !low_power_request)
    else $error("suspend bit not set on wake");
  a_serial_exit: assert property ( // RQ10
    (serial_mode_exit && ifc_op == OP_NONE)
    |=> !ifc_q[SER6] && !ifc_q[SER3])
    else $error("serial bits not cleared");
  a_pump_or: assert property ( // RQ21
    ##1 charge_pump_enable_pin == $past(otg_q[DRV] | otg_q[DRVALT]))
    else $error("charge pump output wrong");
  a_reserved_zero: assert property ( // RQ23
    (reg_rd && reg_addr == FUNC_CLR) |=> !reg_rdata[7])
    else $error("reserved bit read as one");

  c_xcvr_reset: cover property (rif.start ##[1:64] rif.done);
  c_suspend: cover property (low_power_request ##[1:64] low_power_exit);
  c_ext_vbus: cover property (otg_q[EXTSEL] && ifc_q[VBYP] ##1 vbus_valid);
endmodule
`default_nettype wire

/* File: sim/link_model.sv */
// Link-side model issuing single-byte register accesses
`timescale 1ns/10ps
`default_nettype none
module link_model (
  input  wire logic                 sys_clk,
  output logic                      reg_wr,
  output logic                      reg_rd,
  output ulpi_ctrl_pkg::addr_t      reg_addr,
  output ulpi_ctrl_pkg::byte_t      reg_wdata,
  input  wire ulpi_ctrl_pkg::byte_t reg_rdata,
  input  wire logic                 reg_rvalid
);
  import ulpi_ctrl_pkg::*;

  // Idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 6'h3f;
    reg_wdata = 8'h00;
  end

  task automatic wr(input addr_t a, input byte_t d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    // Released lines carry no stale value
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input addr_t a, output byte_t d, output logic v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

/* File: sim/ulpi_phy_control_registers_bench.sv */
// Self-checking bench of the control register bank
`timescale 1ns/10ps
`default_nettype none
module ulpi_phy_control_registers_bench;
  import ulpi_ctrl_pkg::*;
  logic sys_clk, rst_b, reg_wr, reg_rd, reg_rvalid;
  addr_t reg_addr;
  byte_t reg_wdata, reg_rdata;
  logic low_power_exit, serial_mode_exit, car_kit_mode_exit, host_mode;
  logic vbus_comparator_valid, external_vbus_input;
  logic hs_xcvr_enable, fs_xcvr_enable, ls_xcvr_enable, fs_preamble_enable;
  logic termination_select, non_driving, raw_encoding, xcvr_reset_out;
  logic [1:0] encoding_mode_select;
  logic low_power_request, six_pin_serial_enable, three_pin_serial_enable;
  logic car_kit_uart_enable, clock_output_pin_enable, automatic_resume_active;
  logic stop_guard_pullup_enable, id_pin_pullup_enable, dplus_pulldown_enable;
  logic dminus_pulldown_enable, vbus_discharge_enable, vbus_charge_enable;
  logic charge_pump_enable_pin, vbus_valid;
  int   errors, check_count, cycles;

  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  link_model u_link (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid);

  ulpi_phy_control_registers u_dut (.sys_clk, .rst_b, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .low_power_exit,
    .serial_mode_exit, .car_kit_mode_exit, .host_mode,
    .vbus_comparator_valid, .external_vbus_input, .hs_xcvr_enable,
    .fs_xcvr_enable, .ls_xcvr_enable, .fs_preamble_enable,
    .termination_select, .encoding_mode_select, .non_driving, .raw_encoding,
    .xcvr_reset_out, .low_power_request, .six_pin_serial_enable,
    .three_pin_serial_enable, .car_kit_uart_enable, .clock_output_pin_enable,
    .automatic_resume_active, .stop_guard_pullup_enable,
    .id_pin_pullup_enable, .dplus_pulldown_enable, .dminus_pulldown_enable,
    .vbus_discharge_enable, .vbus_charge_enable, .charge_pump_enable_pin,
    .vbus_valid);

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      results();
    end
  end

  // Count and report one comparison
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bitchk(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask

  // Land just after a later edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Read one byte and compare it
  task automatic rdchk(input addr_t a, input byte_t exp);
    byte_t d;
    logic  v;
    u_link.rd(a, d, v);
    bitchk("read valid", v, 1'b1);
    check($sformatf("reg %h", a), d, exp);
  endtask

  task automatic t_reset();
    byte_t rv [3] = '{8'h41, 8'h00, 8'h06};
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 3; k++) begin
        rdchk(addr_t'(4 + 3 * r + k), rv[r]);
      end
    end
    rdchk(6'h20, 8'h00);
    bitchk("fs", fs_xcvr_enable, 1'b1);
    bitchk("low power", low_power_request, 1'b0);
    bitchk("dp pd", dplus_pulldown_enable, 1'b1);
    bitchk("dm pd", dminus_pulldown_enable, 1'b1);
    bitchk("id pu", id_pin_pullup_enable, 1'b0);
    $display("test reset values done");
  endtask

  task automatic t_wsc();
    byte_t w [3] = '{8'h9c, 8'ha5, 8'h81};
    byte_t s [3] = '{8'h80, 8'h50, 8'h60};
    byte_t c [3] = '{8'h0c, 8'h0f, 8'h81};
    byte_t m [3] = '{8'h7f, 8'hff, 8'hff};
    byte_t rv [3] = '{8'h41, 8'h00, 8'h06};
    addr_t b;
    for (int r = 0; r < 3; r++) begin
      b = addr_t'(4 + 3 * r);
      u_link.wr(b, w[r]);
      rdchk(b + 6'h2, w[r] & m[r]);
      u_link.wr(b + 6'h1, s[r]);
      rdchk(b, (w[r] | s[r]) & m[r]);
      u_link.wr(b + 6'h2, c[r]);
      rdchk(b + 6'h1, (w[r] | s[r]) & ~c[r] & m[r]);
      u_link.wr(b, rv[r]);
    end
    $display("test write set clear done");
  endtask

  task automatic t_codes();
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      u_link.wr(FUNC_WR, {3'b010, k, k[0], k});
      tick(2);
      bitchk("hs", hs_xcvr_enable, k == 2'h0);
      bitchk("fs", fs_xcvr_enable, k == 2'h1 || k == 2'h3);
      bitchk("ls", ls_xcvr_enable, k == 2'h2);
      bitchk("preamble", fs_preamble_enable, k == 2'h3);
      bitchk("term", termination_select, k[0]);
      check("enc", {6'h00, encoding_mode_select}, {6'h00, k});
      bitchk("non drive", non_driving, k == 2'h1);
      bitchk("raw", raw_encoding, k == 2'h2);
    end
    u_link.wr(FUNC_WR, 8'h41);
    $display("test codes done");
  endtask

  task automatic t_xrst();
    int n;
    u_link.wr(FUNC_SET, 8'h20);
    #1;
    bitchk("xcvr reset", xcvr_reset_out, 1'b1);
    n = 0;
    while (xcvr_reset_out === 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    check("hold", 8'(n), 8'(XRST_CYCLES));
    tick(2);
    rdchk(FUNC_CLR, 8'h41);
    rdchk(OTG_WR, 8'h06);
    $display("test transceiver reset done");
  endtask

  task automatic t_susp();
    u_link.wr(FUNC_CLR, 8'h40);
    tick(2);
    bitchk("low power", low_power_request, 1'b1);
    @(posedge sys_clk);
    low_power_exit <= 1'b1;
    @(posedge sys_clk);
    low_power_exit <= 1'b0;
    rdchk(FUNC_SET, 8'h41);
    tick(1);
    bitchk("awake", low_power_request, 1'b0);
    $display("test suspend done");
  endtask

  task automatic t_modes();
    u_link.wr(IFC_SET, 8'h07);
    tick(2);
    bitchk("six", six_pin_serial_enable, 1'b1);
    bitchk("three", three_pin_serial_enable, 1'b1);
    bitchk("car kit", car_kit_uart_enable, 1'b1);
    bitchk("clk off", clock_output_pin_enable, 1'b0);
    u_link.wr(IFC_SET, 8'h08);
    tick(2);
    bitchk("clk on", clock_output_pin_enable, 1'b1);
    @(posedge sys_clk);
    serial_mode_exit <= 1'b1;
    @(posedge sys_clk);
    serial_mode_exit <= 1'b0;
    rdchk(IFC_CLR, 8'h0c);
    @(posedge sys_clk);
    car_kit_mode_exit <= 1'b1;
    @(posedge sys_clk);
    car_kit_mode_exit <= 1'b0;
    rdchk(IFC_WR, 8'h08);
    $display("test pin modes done");
  endtask

  task automatic t_line();
    logic sel, inv, byp, ext, cmp;
    u_link.wr(IFC_WR, 8'h90);
    tick(2);
    bitchk("resume", automatic_resume_active, 1'b0);
    bitchk("guard", stop_guard_pullup_enable, 1'b0);
    @(posedge sys_clk);
    host_mode <= 1'b1;
    tick(2);
    bitchk("resume", automatic_resume_active, 1'b1);
    u_link.wr(OTG_WR, 8'h19);
    tick(2);
    check("otg",
      {3'h0, vbus_charge_enable, vbus_discharge_enable,
      dminus_pulldown_enable, dplus_pulldown_enable,
      id_pin_pullup_enable}, 8'h19);
    bitchk("pump", charge_pump_enable_pin, 1'b0);
    for (int i = 1; i < 4; i++) begin
      u_link.wr(OTG_WR, {1'b0, 2'(i), 5'h00});
      tick(2);
      bitchk("pump", charge_pump_enable_pin, 1'b1);
    end
    for (int i = 0; i < 32; i++) begin
      {sel, inv, byp, ext, cmp} = 5'(i);
      u_link.wr(IFC_WR, {1'b0, byp, inv, 5'h00});
      u_link.wr(OTG_WR, {sel, 7'h06});
      @(posedge sys_clk);
      external_vbus_input   <= ext;
      vbus_comparator_valid <= cmp;
      tick(5);
      bitchk("vbus valid", vbus_valid,
        sel ? ((ext ^ inv) & (byp | cmp)) : cmp);
    end
    $display("test line controls done");
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b                 = 1'b0;
    low_power_exit        = 1'b0;
    serial_mode_exit      = 1'b0;
    car_kit_mode_exit     = 1'b0;
    host_mode             = 1'b0;
    vbus_comparator_valid = 1'b0;
    external_vbus_input   = 1'b0;
    errors                = 0;
    check_count           = 0;
    cycles                = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset();
    t_wsc();
    t_codes();
    t_xrst();
    t_susp();
    t_modes();
    t_line();
    results();
  end
endmodule
`default_nettype wire
